//--- hw/slt_pkg.sv
// Package of constants and types for the state logic trigger
package slt_pkg;

  // ----------------------------------------------------------------
  // Widths and encodings
  // ----------------------------------------------------------------
  localparam int unsigned SAMPLE_W_DEF   = 12;         // Default sample width
  localparam int unsigned NUM_DATA       = 3;          // Data operand channels
  localparam int unsigned NUM_CHAN       = 4;          // All thresholded channels
  localparam int unsigned CLK_CHAN       = 3;          // Index of the state clock channel
  localparam int unsigned AUTO_TO_W      = 32;         // Width of auto timeout count
  localparam logic [31:0] AUTO_TO_DEF    = 32'h000F4240; // Default auto timeout, cycles

  // Qualifier codes per data channel
  localparam logic [1:0]  QUAL_CARE_X    = 2'h0;       // Don't care
  localparam logic [1:0]  QUAL_HIGH      = 2'h1;
  localparam logic [1:0]  QUAL_LOW       = 2'h2;

  // Combining function codes
  localparam logic [1:0]  FN_AND         = 2'h0;
  localparam logic [1:0]  FN_OR          = 2'h1;
  localparam logic [1:0]  FN_NAND        = 2'h2;
  localparam logic [1:0]  FN_NOR         = 2'h3;

  // Reset values
  localparam logic        RST_LEVEL      = 1'h0;

  // Acquisition control states
  typedef enum logic [1:0] {
    SLT_ARMED,
    SLT_FIRE
  } slt_acq_state_t;

endpackage : slt_pkg

//--- hw/slt_thr_if.sv
// Interface carrying thresholded channel levels between comparator and trigger core
`timescale 1ns/1ps
interface slt_thr_if;
  logic [3:0] level;      // Thresholded level per channel
  logic [3:0] level_prev; // Level one sample earlier

  modport cmp (output level, output level_prev);
  modport core (input level, input level_prev);
endinterface : slt_thr_if

//--- hw/slt_threshold.sv
// Per-channel threshold comparators with registered levels
`timescale 1ns/1ps
module slt_threshold
  import slt_pkg::*;
#(
  parameter int unsigned SAMPLE_W = SAMPLE_W_DEF
) (
  input  wire logic                         sys_clk_in,
  input  wire logic                         srst_in,
  input  wire logic [NUM_CHAN*SAMPLE_W-1:0] sample_in,
  input  wire logic [NUM_CHAN*SAMPLE_W-1:0] threshold_in,
  slt_thr_if.cmp                            thr
);

  // ----------------------------------------------------------------
  // Comparators
  // ----------------------------------------------------------------
  logic [NUM_CHAN-1:0] level_ff;
  logic [NUM_CHAN-1:0] prev_ff;
  logic [NUM_CHAN-1:0] cmp;

  // Each channel against its own threshold; high when at or above
  // Reset loads both stages with the live level: a channel idling high gives no false edge on release
  for (genvar g = 0; g < NUM_CHAN; g++) begin : g_cmp
    assign cmp[g] = (sample_in[g*SAMPLE_W +: SAMPLE_W] >= threshold_in[g*SAMPLE_W +: SAMPLE_W]);
    always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
        level_ff[g] <= cmp[g];
        prev_ff[g]  <= cmp[g];
      end else begin
        level_ff[g] <= cmp[g];
        prev_ff[g]  <= level_ff[g];
      end
    end
  end

  assign thr.level      = level_ff;
  assign thr.level_prev = prev_ff;

endmodule : slt_threshold

//--- hw/slt_trigger.sv
// State logic trigger: clocked Boolean trigger with auto and normal acquisition
`timescale 1ns/1ps
module slt_trigger
  import slt_pkg::*;
#(
  parameter int unsigned SAMPLE_W = SAMPLE_W_DEF
) (
  input  wire logic                         sys_clk_in,
  input  wire logic                         srst_in,
  input  wire logic [NUM_CHAN*SAMPLE_W-1:0] sample_in,
  input  wire logic [NUM_CHAN*SAMPLE_W-1:0] threshold_in,
  input  wire logic [2*NUM_DATA-1:0]        qual_in,
  input  wire logic [1:0]                   func_in,
  input  wire logic                         clk_rising_in,
  input  wire logic                         when_true_in,
  input  wire logic                         auto_mode_in,
  input  wire logic [AUTO_TO_W-1:0]         auto_timeout_in,
  input  wire logic                         acq_done_in,
  output logic                              trigger_out,
  output logic                              acquire_out,
  output logic                              forced_out,
  output logic                              state_result_out
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (SAMPLE_W < 1 || SAMPLE_W > 32) begin : g_bad_w
    $error("slt_trigger: SAMPLE_W out of range");
  end

  // ----------------------------------------------------------------
  // Threshold stage
  // ----------------------------------------------------------------
  slt_thr_if thr ();

  slt_threshold #(
    .SAMPLE_W     (SAMPLE_W)
  ) u_thr (
    .sys_clk_in   (sys_clk_in),
    .srst_in      (srst_in),
    .sample_in    (sample_in),
    .threshold_in (threshold_in),
    .thr          (thr.cmp)
  );

  // ----------------------------------------------------------------
  // State clock edge and Boolean function
  // ----------------------------------------------------------------
  logic                state_clock_channel;
  logic                state_clock_prev;
  logic                clk_edge;
  logic [NUM_DATA-1:0] term;
  logic [NUM_DATA-1:0] care;
  logic                and_v;
  logic                or_v;
  logic                fn_val;
  logic                match;

  assign state_clock_channel = thr.level[CLK_CHAN];
  assign state_clock_prev    = thr.level_prev[CLK_CHAN];

  // Only a crossing on the chosen slope counts; levels alone never qualify
  assign clk_edge = clk_rising_in ? (state_clock_channel & ~state_clock_prev)
                                  : (~state_clock_channel & state_clock_prev);

  // Per-input qualifier: term true when the level equals the qualifier
  for (genvar g = 0; g < NUM_DATA; g++) begin : g_qual
    assign care[g] = (qual_in[2*g +: 2] == QUAL_HIGH) || (qual_in[2*g +: 2] == QUAL_LOW);
    assign term[g] = (qual_in[2*g +: 2] == QUAL_HIGH) ? thr.level[g] : ~thr.level[g];
  end

  // Don't care inputs are neutral: one for AND, zero for OR
  always_comb begin
    and_v = &(term | ~care);
    or_v  = |(term & care);
    case (func_in)
      FN_AND:  fn_val = and_v;
      FN_OR:   fn_val = or_v;
      FN_NAND: fn_val = ~and_v;
      FN_NOR:  fn_val = ~or_v;
      default: fn_val = and_v;
    endcase
  end

  // Goes TRUE matches a true result, goes FALSE a false one
  assign match = (fn_val == when_true_in);

  // ----------------------------------------------------------------
  // Trigger pulse and sampled result
  // ----------------------------------------------------------------
  logic trig_ff;
  logic result_ff;

  // Evaluation happens only on the qualifying edge
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      trig_ff   <= 1'h0;
      result_ff <= 1'h0;
    end else begin
      trig_ff <= clk_edge & match;
      if (clk_edge) begin
        result_ff <= fn_val;
      end
    end
  end

  assign trigger_out      = trig_ff;
  assign state_result_out = result_ff;

  // ----------------------------------------------------------------
  // Acquisition control: auto and normal modes
  // ----------------------------------------------------------------
  slt_acq_state_t          state_ff;
  logic [AUTO_TO_W-1:0]    wait_ff;
  logic                    acq_ff;
  logic                    forced_ff;
  logic                    timeout_hit;

  assign timeout_hit = auto_mode_in && (wait_ff >= auto_timeout_in) && (auto_timeout_in != '0);

  // Armed waits for a trigger or, in auto mode, the timeout; fire holds until acquisition done
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      state_ff  <= SLT_ARMED;
      wait_ff   <= '0;
      acq_ff    <= 1'h0;
      forced_ff <= 1'h0;
    end else begin
      case (state_ff)
        SLT_ARMED: begin
          if (trig_ff) begin
            state_ff  <= SLT_FIRE;
            acq_ff    <= 1'h1;
            forced_ff <= 1'h0;
            wait_ff   <= '0;
          end else if (timeout_hit) begin
            state_ff  <= SLT_FIRE;
            acq_ff    <= 1'h1;
            forced_ff <= 1'h1;
            wait_ff   <= '0;
          end else if (auto_mode_in) begin
            wait_ff <= wait_ff + AUTO_TO_W'(1'h1);
          end else begin
            wait_ff <= '0;            // Normal mode never forces
          end
        end
        SLT_FIRE: begin
          if (acq_done_in) begin
            state_ff  <= SLT_ARMED;
            acq_ff    <= 1'h0;
            forced_ff <= 1'h0;
          end
        end
        default: begin
          state_ff <= SLT_ARMED;
          acq_ff   <= 1'h0;
        end
      endcase
    end
  end

  assign acquire_out = acq_ff;
  assign forced_out  = forced_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_rise_edge;
    !state_clock_channel ##1 state_clock_channel;
  endsequence

  sequence s_fall_edge;
    state_clock_channel ##1 !state_clock_channel;
  endsequence

  a_trig_needs_edge: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    trig_ff |-> $past(clk_edge)) else $error("trigger without qualifying clock edge");

  a_trig_on_match: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (clk_edge && match) |=> trig_ff) else $error("matching edge gave no trigger");

  a_no_trig_mismatch: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (clk_edge && !match) |=> !trig_ff) else $error("trigger on mismatching result");

  a_rise_slope_only: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (clk_rising_in && clk_edge) |-> state_clock_channel && !state_clock_prev) else $error("wrong slope edge");

  a_fall_slope_only: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (!clk_rising_in && clk_edge) |-> !state_clock_channel && state_clock_prev) else $error("wrong slope edge");

  a_rise_edge_seen: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (s_rise_edge ##0 clk_rising_in) |-> clk_edge)
    else $error("rising state clock edge missed");

  a_fall_edge_seen: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (s_fall_edge ##0 !clk_rising_in) |-> clk_edge)
    else $error("falling state clock edge missed");

  a_nand_inverts_and: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (clk_edge && func_in == FN_NAND && care == '0) |=> !state_result_out) else $error("nand result wrong");

  a_dontcare_all_and: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (care == '0 && func_in == FN_AND) |-> fn_val) else $error("don't care not neutral");

  a_normal_no_force: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (!auto_mode_in && state_ff == SLT_ARMED && !trig_ff) |=> !acq_ff) else $error("normal mode forced acquisition");

  a_trig_acquires: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (state_ff == SLT_ARMED && trig_ff) |=> acq_ff && !forced_ff) else $error("trigger did not start acquisition");

endmodule : slt_trigger

//--- verif/slt_chan_model.sv
// Partner model: thresholded analog sources and acquisition control
`timescale 1ns/1ps
module slt_chan_model
  import slt_pkg::*;
#(
  parameter int unsigned SAMPLE_W = SAMPLE_W_DEF,
  parameter int unsigned DONE_DLY = 3
) (
  input  wire logic                         sys_clk_in,
  input  wire logic [NUM_CHAN-1:0]          lvl_in,
  input  wire logic                         acquire_in,
  output logic      [NUM_CHAN*SAMPLE_W-1:0] sample_out,
  output logic      [NUM_CHAN*SAMPLE_W-1:0] threshold_out,
  output logic                              acq_done_out
);
  int unsigned wait_cnt = 0;
  // ----------------------------------------
  // Sources
  // ----------------------------------------
  // Distinct threshold per channel; a high sits exactly on it to probe the boundary
  always_comb begin
    for (int k = 0; k < NUM_CHAN; k++) begin
      threshold_out[k*SAMPLE_W +: SAMPLE_W] = SAMPLE_W'((k + 1) * 'h100);
      sample_out[k*SAMPLE_W +: SAMPLE_W] = SAMPLE_W'((k + 1) * 'h100 - (lvl_in[k] ? 0 : 1));
    end
  end
  // Ends each acquisition after a few cycles, like a slow record fill
  initial acq_done_out = 1'b0;
  always @(negedge sys_clk_in) begin
    wait_cnt = acquire_in ? wait_cnt + 1 : 0;
    acq_done_out = (wait_cnt >= DONE_DLY);
  end
endmodule : slt_chan_model

//--- verif/tb_state_logic_trigger.sv
// Self-checking testbench for the state logic trigger
`timescale 1ns/1ps
module tb_state_logic_trigger;
  import slt_pkg::*;
  logic        sys_clk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic [3:0]  lvl = 4'h0;
  logic [5:0]  qual = 6'h00;
  logic [1:0]  func = FN_AND;
  logic        clk_rising = 1'b1;
  logic        when_true = 1'b1;
  logic        auto_mode = 1'b0;
  logic [31:0] auto_to = 32'h00000014;
  logic [47:0] sample;
  logic [47:0] thr;
  logic        acq_done;
  logic        trig;
  logic        acq;
  logic        forced;
  logic        res;
  int          failures = 0;
  int          comparisons = 0;

  // ----------------------------------------
  // Instances
  // ----------------------------------------
  slt_trigger i_slt_trigger (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .sample_in(sample),
    .threshold_in(thr), .qual_in(qual), .func_in(func), .clk_rising_in(clk_rising),
    .when_true_in(when_true), .auto_mode_in(auto_mode), .auto_timeout_in(auto_to),
    .acq_done_in(acq_done), .trigger_out(trig), .acquire_out(acq), .forced_out(forced),
    .state_result_out(res));
  slt_chan_model i_slt_chan_model (.sys_clk_in(sys_clk_in), .lvl_in(lvl), .acquire_in(acq),
    .sample_out(sample), .threshold_out(thr), .acq_done_out(acq_done));

  initial forever #2.5 sys_clk_in = ~sys_clk_in;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  // Expected function value; codes other than high or low drop out
  function automatic logic eval_fn(input logic [2:0] d);
    logic a = 1'b1;
    logic o = 1'b0;
    for (int k = 0; k < 3; k++) begin
      if (qual[2*k +: 2] inside {QUAL_HIGH, QUAL_LOW}) begin
        a &= (qual[2*k +: 2] == QUAL_HIGH) ? d[k] : ~d[k];
        o |= (qual[2*k +: 2] == QUAL_HIGH) ? d[k] : ~d[k];
      end
    end
    return (func == FN_AND) ? a : (func == FN_OR) ? o : (func == FN_NAND) ? ~a : ~o;
  endfunction : eval_fn

  // Waits for the acquisition started by a trigger to drain
  task automatic drain();
    for (int i = 0; i < 30 && acq !== 1'b0; i++) @(negedge sys_clk_in);
    check("acquire_idle", acq, 1'b0);
  endtask : drain

  // One qualifying edge on the state clock channel with data d
  task automatic do_edge(input logic [2:0] d);
    logic exp_res;
    int   seen;
    exp_res = eval_fn(d);
    seen = 0;
    lvl = {~clk_rising, d};
    @(negedge sys_clk_in);
    lvl[3] = clk_rising;
    for (int i = 0; i < 5; i++) begin
      @(negedge sys_clk_in);
      if (trig === 1'b1) begin
        seen++;
        @(negedge sys_clk_in);
        check("acquire", {acq, forced}, 2'b10);
      end
    end
    check("trigger", seen, exp_res == when_true);
    check("trigger_pulse", trig, 1'b0);
    check("result", res, exp_res);
    drain();
  endtask : do_edge

  // Every function with several qualifier sets, incl. code 3 and all don't care
  task automatic t_functions();
    logic [5:0] qs[4] = '{6'h00, 6'h09, 6'h25, 6'h3F};
    for (int f = 0; f < 4; f++) begin
      func = 2'(f);
      foreach (qs[q]) begin
        qual = qs[q];
        for (int d = 0; d < 8; d += 3) do_edge(3'(d));
      end
    end
  endtask : t_functions

  // Falling slope, goes-false, and no trigger without a qualifying edge
  task automatic t_slope();
    int seen = 0;
    clk_rising = 1'b0;
    when_true = 1'b0;
    func = FN_OR;
    qual = 6'h15;
    do_edge(3'h0);
    do_edge(3'h7);
    lvl = 4'h7;
    repeat (10) begin
      @(negedge sys_clk_in);
      lvl[2:0] = ~lvl[2:0];
      if (trig === 1'b1) seen++;
    end
    check("no_edge_trigger", seen, 0);
    clk_rising = 1'b1;
    when_true = 1'b1;
  endtask : t_slope

  // Auto mode forces after the timeout; normal mode never does
  task automatic t_auto();
    int n = 0;
    auto_mode = 1'b1;
    while (acq !== 1'b1 && n < 60) begin
      @(negedge sys_clk_in);
      n++;
    end
    check("forced", {acq, forced, 1'(n >= 20)}, 3'b111);
    drain();
    auto_mode = 1'b0;
    repeat (60) @(negedge sys_clk_in);
    check("normal_idle", acq, 1'b0);
    auto_mode = 1'b1;
    auto_to = 32'h00000000;
    repeat (60) @(negedge sys_clk_in);
    check("zero_timeout_idle", acq, 1'b0);
    auto_mode = 1'b0;
    auto_to = 32'h00000014;
  endtask : t_auto

  // Mid-run reset with the state clock channel held high: outputs clear, no false edge
  task automatic t_reset();
    int seen = 0;
    func = FN_NOR;
    srst_in = 1'b1;
    lvl = 4'h8;
    repeat (3) @(negedge sys_clk_in);
    check("reset_outs", {trig, acq, forced, res}, 4'h0);
    srst_in = 1'b0;
    repeat (6) begin
      @(negedge sys_clk_in);
      if (trig === 1'b1) seen++;
    end
    check("reset_no_edge", seen, 0);
    do_edge(3'h0);
  endtask : t_reset

  initial begin
    repeat (12) @(negedge sys_clk_in);
    srst_in = 1'b0;
    @(negedge sys_clk_in);
    check("release_outs", {trig, acq, forced, res}, 4'h0);
    t_functions();
    t_slope();
    t_auto();
    t_reset();
    end_sim();
  end

  // Watchdog well beyond the expected run of several hundred cycles
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    failures++;
    end_sim();
  end
endmodule : tb_state_logic_trigger
